// [logic/rms_pkg.sv]
package rms_pkg;
  // Frame bytes
  localparam logic [7:0] FRAME_START    = 8'h02;
  localparam logic [7:0] CMD_SET        = 8'h09;
  localparam logic [7:0] CMD_GET        = 8'h0A;
  localparam logic [7:0] RSP_SET        = 8'h49;
  localparam logic [7:0] RSP_GET        = 8'h4A;
  localparam logic [7:0] STATUS_OK      = 8'h00;
  localparam logic [7:0] STATUS_FAIL    = 8'h01;
  localparam logic [7:0] LEN_STATUS     = 8'h01;
  localparam logic [7:0] LEN_GET_REQ    = 8'h02;
  // Setting offsets
  localparam logic [7:0] OFF_CHANNEL    = 8'h00;
  localparam logic [7:0] OFF_RATE       = 8'h01;
  localparam logic [7:0] OFF_SUBNET     = 8'h02;
  localparam logic [7:0] OFF_ADDR       = 8'h03;
  localparam logic [7:0] OFF_POWER      = 8'h04;
  localparam logic [7:0] OFF_FLAGS      = 8'h05;
  localparam logic [7:0] OFF_BAUD       = 8'h3C;
  localparam logic [7:0] BAUD_BYTES     = 8'h04;
  // Reset values
  localparam logic [7:0]  DEF_CHANNEL   = 8'h06;
  localparam logic [7:0]  DEF_RATE      = 8'h01;
  localparam logic [7:0]  DEF_SUBNET    = 8'hA9;
  localparam logic [7:0]  DEF_ADDR      = 8'h00;
  localparam logic [7:0]  DEF_POWER     = 8'h0A;
  localparam logic [7:0]  DEF_FLAGS     = 8'h09;
  localparam logic [31:0] DEF_BAUD      = 32'h0000_2580;
  // Limits
  localparam logic [31:0] BAUD_MIN      = 32'h0000_012C;
  localparam logic [31:0] BAUD_MAX      = 32'h0001_C200;
  localparam logic [7:0]  ADDR_MAX      = 8'hFE;
  localparam logic [7:0]  ADDR_BCAST    = 8'hFF;
  localparam int          SUBNET_USABLE = 248;
  // Flag bit positions
  localparam int FLAG_LED  = 0;
  localparam int FLAG_FRAG = 1;
  localparam int FLAG_IND  = 3;

  typedef struct packed {
    logic [7:0] channel;
    logic [7:0] subnet;
    logic [7:0] src;
    logic [7:0] dst;
  } rms_hdr_t;

  typedef struct packed {
    logic [7:0]  channel;
    logic [7:0]  rate;
    logic [7:0]  subnet;
    logic [7:0]  addr;
    logic [7:0]  power;
    logic [7:0]  flags;
    logic [31:0] baud;
  } rms_cfg_t;

  localparam rms_cfg_t CFG_DEFAULT = '{DEF_CHANNEL, DEF_RATE, DEF_SUBNET, DEF_ADDR,
                                       DEF_POWER, DEF_FLAGS, DEF_BAUD};

  // Subnets that collide with the radio sync pattern are refused
  function automatic logic subnet_ok(input logic [7:0] s);
    unique case (s)
      8'h00, 8'h30, 8'h33, 8'h63, 8'h66, 8'h92, 8'h99, 8'hCC: subnet_ok = 1'b0;
      default: subnet_ok = 1'b1;
    endcase
  endfunction : subnet_ok
endpackage : rms_pkg

// [logic/rms_settings.sv]
// Summary of operation
// - Subnet byte at 0x02, default 169, applied on restart request
// - Up to 248 usable subnets per channel
// - Traffic only with same subnet and channel
// - Set frame: start, 0x09, length, offset, data, checksum
// - Set reply: 02 49 01 00 checksum
// - Get frame 0x0A; reply 0x4A, offset, data
// - Own address at 0x03, 0..254, default 0
// - Own address is sender of sent packets
// - Accept packets addressed to own address or broadcast only
// - Destination 0xFF is broadcast, received whatever the own address on own channel and subnet
// - Flag byte at 0x05, default 9, OR-combined
// - Flag bit 0 drives activity LEDs low
// - Flag bit 1 enables fragmentation mode
// - Bit 3 with bit 1 reports each fragment
// - Baud rate four bytes at 0x3C, default 9600
// - Multi-byte parameters sent least byte first
// - Invalid stored baud falls back to default
module rms_settings
  import rms_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // Restart request: stored settings take effect
  input  wire logic       apply_req,
  // Host command bytes in
  input  wire logic       rx_byte_valid,
  input  wire logic [7:0] rx_byte,
  output logic            rx_byte_ready,
  // Host reply bytes out
  output logic            tx_byte_valid,
  output logic [7:0]      tx_byte,
  input  wire logic       tx_byte_ready,
  // Radio packet headers
  input  wire logic       pkt_valid,
  input  wire rms_hdr_t   pkt_hdr,
  input  wire logic       pkt_is_fragment,
  output logic            pkt_accept,
  output logic            fragment_received_indication,
  output logic            fragment_drop,
  // Transmit header and activity
  output rms_hdr_t        tx_hdr_base,
  input  wire logic       radio_tx_busy,
  input  wire logic       radio_rx_busy,
  output logic            transmit_activity_led_b,
  output logic            receive_activity_led_b,
  // Settings in effect
  output rms_cfg_t        active_cfg,
  output logic            frag_mode
);

  localparam int RESP_BYTES = 9;

  // Elaboration guard on the subnet budget per channel
  if (SUBNET_USABLE != 248) begin : g_subnet_chk
    $error("Usable subnet count must be 248");
  end

  typedef enum {S_IDLE, S_CMD, S_LEN, S_BODY, S_CSUM, S_EXEC, S_SEND} rms_state_t;

  rms_state_t           st_q, st_d;
  logic [7:0]           cmd_q, cmd_d;
  logic [7:0]           len_q, len_d;
  logic [7:0]           cnt_q, cnt_d;
  logic [7:0]           off_q, off_d;
  logic [31:0]          par_q, par_d;
  logic [7:0]           cs_q, cs_d;
  logic                 good_q, good_d;
  rms_cfg_t             store_q, store_d;
  logic [RESP_BYTES-1:0][7:0] resp_q, resp_d;
  logic [3:0]           rn_q, rn_d;

  // Host side is stalled while a reply is pending
  assign rx_byte_ready = (st_q != S_EXEC) && (st_q != S_SEND);
  assign tx_byte_valid = (st_q == S_SEND);
  assign tx_byte       = resp_q[0];

  // Byte read of the stored map; zero for unmapped offsets
  function automatic logic [7:0] map_byte(input rms_cfg_t c, input logic [7:0] o);
    unique case (o)
      OFF_CHANNEL:       map_byte = c.channel;
      OFF_RATE:          map_byte = c.rate;
      OFF_SUBNET:        map_byte = c.subnet;
      OFF_ADDR:          map_byte = c.addr;
      OFF_POWER:         map_byte = c.power;
      OFF_FLAGS:         map_byte = c.flags;
      OFF_BAUD:          map_byte = c.baud[7:0];
      OFF_BAUD + 8'h01:  map_byte = c.baud[15:8];
      OFF_BAUD + 8'h02:  map_byte = c.baud[23:16];
      OFF_BAUD + 8'h03:  map_byte = c.baud[31:24];
      default:           map_byte = 8'h00;
    endcase
  endfunction : map_byte

  // Parser, store and reply builder
  always_comb begin
    logic [7:0] nparam;
    logic [7:0] x;
    logic       ok;
    logic [1:0] pidx;
    nparam  = len_q - 8'h01;
    pidx    = cnt_q[1:0] - 2'd1;
    x       = 8'h00;
    ok      = 1'b0;
    st_d    = st_q;
    cmd_d   = cmd_q;
    len_d   = len_q;
    cnt_d   = cnt_q;
    off_d   = off_q;
    par_d   = par_q;
    cs_d    = cs_q;
    good_d  = good_q;
    store_d = store_q;
    resp_d  = resp_q;
    rn_d    = rn_q;
    unique case (st_q)
      S_IDLE: begin
        if (rx_byte_valid && rx_byte == FRAME_START) begin
          cs_d = rx_byte;
          st_d = S_CMD;
        end
      end
      S_CMD: begin
        if (rx_byte_valid) begin
          cmd_d = rx_byte;
          cs_d  = cs_q ^ rx_byte;
          st_d  = S_LEN;
        end
      end
      S_LEN: begin
        if (rx_byte_valid) begin
          len_d  = rx_byte;
          cs_d   = cs_q ^ rx_byte;
          cnt_d  = 8'h00;
          par_d  = 32'h0;
          good_d = (rx_byte != 8'h00) && (rx_byte <= BAUD_BYTES + 8'h01);
          st_d   = (rx_byte == 8'h00) ? S_CSUM : S_BODY;
        end
      end
      S_BODY: begin
        if (rx_byte_valid) begin
          cs_d = cs_q ^ rx_byte;
          if (cnt_q == 8'h00) begin
            off_d = rx_byte;
          end else if (cnt_q <= BAUD_BYTES) begin
            // Lane index kept at two bits: a 32-bit difference would wrap out of range
            par_d[8*pidx +: 8] = rx_byte;
          end
          cnt_d = cnt_q + 8'h01;
          if (cnt_q + 8'h01 == len_q) begin
            st_d = S_CSUM;
          end
        end
      end
      S_CSUM: begin
        if (rx_byte_valid) begin
          // A frame with a bad checksum is dropped without a reply
          st_d = (rx_byte == cs_q && (cmd_q == CMD_SET || cmd_q == CMD_GET)) ?
                 S_EXEC : S_IDLE;
        end
      end
      S_EXEC: begin
        resp_d    = '0;
        resp_d[0] = FRAME_START;
        if (cmd_q == CMD_SET) begin
          // Values change only the stored copy until the next restart
          if (good_q && nparam == 8'h01) begin
            unique case (off_q)
              OFF_CHANNEL: begin store_d.channel = par_q[7:0]; ok = 1'b1; end
              OFF_RATE:    begin store_d.rate    = par_q[7:0]; ok = 1'b1; end
              OFF_SUBNET: begin
                ok = subnet_ok(par_q[7:0]);
                if (ok) store_d.subnet = par_q[7:0];
              end
              OFF_ADDR: begin
                ok = (par_q[7:0] <= ADDR_MAX);
                if (ok) store_d.addr = par_q[7:0];
              end
              OFF_POWER:   begin store_d.power   = par_q[7:0]; ok = 1'b1; end
              OFF_FLAGS:   begin store_d.flags   = par_q[7:0]; ok = 1'b1; end
              default:     ok = 1'b0;
            endcase
          end else if (good_q && nparam == BAUD_BYTES && off_q == OFF_BAUD) begin
            store_d.baud = par_q;
            ok           = 1'b1;
          end
          resp_d[1] = RSP_SET;
          resp_d[2] = LEN_STATUS;
          resp_d[3] = ok ? STATUS_OK : STATUS_FAIL;
          rn_d      = 4'd5;
        end else begin
          ok = good_q && len_q == LEN_GET_REQ &&
               ((off_q <= OFF_FLAGS && par_q[7:0] == 8'h01) ||
                (off_q == OFF_BAUD && par_q[7:0] == BAUD_BYTES));
          resp_d[1] = RSP_GET;
          if (ok) begin
            resp_d[2] = par_q[7:0] + 8'h01;
            resp_d[3] = off_q;
            for (int i = 0; i < 4; i++) begin
              if (8'(i) < par_q[7:0]) resp_d[4+i] = map_byte(store_q, off_q + 8'(i));
            end
            rn_d = 4'(par_q[3:0] + 4'd5);
          end else begin
            resp_d[2] = LEN_STATUS;
            resp_d[3] = STATUS_FAIL;
            rn_d      = 4'd5;
          end
        end
        // Trailing checksum over every byte before it
        for (int i = 0; i < RESP_BYTES - 1; i++) begin
          x = x ^ resp_d[i];
        end
        resp_d[rn_d - 4'd1] = x;
        st_d = S_SEND;
      end
      S_SEND: begin
        if (tx_byte_ready) begin
          resp_d = {8'h00, resp_q[RESP_BYTES-1:1]};
          rn_d   = rn_q - 4'd1;
          if (rn_q == 4'd1) st_d = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q    <= S_IDLE;
      cmd_q   <= 8'h00;
      len_q   <= 8'h00;
      cnt_q   <= 8'h00;
      off_q   <= 8'h00;
      par_q   <= 32'h0;
      cs_q    <= 8'h00;
      good_q  <= 1'b0;
      store_q <= CFG_DEFAULT;
      resp_q  <= '0;
      rn_q    <= 4'd0;
    end else begin
      st_q    <= st_d;
      cmd_q   <= cmd_d;
      len_q   <= len_d;
      cnt_q   <= cnt_d;
      off_q   <= off_d;
      par_q   <= par_d;
      cs_q    <= cs_d;
      good_q  <= good_d;
      store_q <= store_d;
      resp_q  <= resp_d;
      rn_q    <= rn_d;
    end
  end

  // Active copy and radio-facing outputs
  rms_cfg_t   act_q, act_d;
  logic       acc_q, acc_d;
  logic       ind_q, ind_d;
  logic       drop_q, drop_d;
  logic       ledt_q, ledt_d;
  logic       ledr_q, ledr_d;

  always_comb begin
    logic match;
    match = 1'b0;
    act_d = act_q;
    if (apply_req) begin
      act_d = store_q;
      // A baud outside the legal span would lock the host out, so use the default
      if (store_q.baud < BAUD_MIN || store_q.baud > BAUD_MAX) act_d.baud = DEF_BAUD;
    end
    match  = pkt_valid && pkt_hdr.channel == act_q.channel &&
             pkt_hdr.subnet == act_q.subnet &&
             (pkt_hdr.dst == act_q.addr || pkt_hdr.dst == ADDR_BCAST);
    // Fragments are useless unless fragmentation mode is on
    acc_d  = match && (!pkt_is_fragment || act_q.flags[FLAG_FRAG]);
    drop_d = match && pkt_is_fragment && !act_q.flags[FLAG_FRAG];
    ind_d  = acc_d && pkt_is_fragment && act_q.flags[FLAG_IND];
    ledt_d = !(act_q.flags[FLAG_LED] && radio_tx_busy);
    ledr_d = !(act_q.flags[FLAG_LED] && radio_rx_busy);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      act_q  <= CFG_DEFAULT;
      acc_q  <= 1'b0;
      ind_q  <= 1'b0;
      drop_q <= 1'b0;
      ledt_q <= 1'b1;
      ledr_q <= 1'b1;
    end else begin
      act_q  <= act_d;
      acc_q  <= acc_d;
      ind_q  <= ind_d;
      drop_q <= drop_d;
      ledt_q <= ledt_d;
      ledr_q <= ledr_d;
    end
  end

  assign active_cfg                   = act_q;
  assign frag_mode                    = act_q.flags[FLAG_FRAG];
  assign pkt_accept                   = acc_q;
  assign fragment_received_indication = ind_q;
  assign fragment_drop                = drop_q;
  assign transmit_activity_led_b      = ledt_q;
  assign receive_activity_led_b       = ledr_q;
  // Sender field always carries the active own address; dst is filled by the sender path
  assign tx_hdr_base = '{act_q.channel, act_q.subnet, act_q.addr, ADDR_BCAST};

endmodule : rms_settings

// [bench/rms_settings_props.sv]
module rms_settings_props
  import rms_pkg::*;
(
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_b,
  // Host side
  input wire logic       apply_req,
  input wire logic       rx_byte_ready,
  input wire logic       tx_byte_valid,
  input wire logic [7:0] tx_byte,
  input wire logic       tx_byte_ready,
  // Radio side
  input wire logic       pkt_valid,
  input wire rms_hdr_t   pkt_hdr,
  input wire logic       pkt_is_fragment,
  input wire logic       pkt_accept,
  input wire logic       fragment_received_indication,
  input wire logic       fragment_drop,
  input wire rms_hdr_t   tx_hdr_base,
  input wire logic       radio_tx_busy,
  input wire logic       radio_rx_busy,
  input wire logic       transmit_activity_led_b,
  input wire logic       receive_activity_led_b,
  input wire rms_cfg_t   active_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // Header is for us: own channel and subnet, own address or broadcast
  logic hit;
  logic take;
  assign hit  = pkt_hdr.channel == active_cfg.channel && pkt_hdr.subnet == active_cfg.subnet
                && (pkt_hdr.dst == active_cfg.addr || pkt_hdr.dst == ADDR_BCAST);
  assign take = pkt_valid && hit && (!pkt_is_fragment || active_cfg.flags[FLAG_FRAG]);

  a_pkt_taken: assert property (take |=> pkt_accept)
    else $error("matching packet not accepted");
  a_pkt_refused: assert property (!take |=> !pkt_accept)
    else $error("packet accepted without a match");
  a_frag_report: assert property (fragment_received_indication |->
    $past(take && pkt_is_fragment && active_cfg.flags[FLAG_IND])) else $error("stray report");
  a_frag_dropped: assert property (pkt_valid && hit && pkt_is_fragment
    && !active_cfg.flags[FLAG_FRAG] |=> fragment_drop && !pkt_accept) else $error("no drop");
  a_transmit_activity_led_low: assert property (1'b1 |=> transmit_activity_led_b ==
    !$past(radio_tx_busy && active_cfg.flags[FLAG_LED])) else $error("tx led wrong");
  a_receive_activity_led_low: assert property (radio_rx_busy && active_cfg.flags[FLAG_LED]
    |=> !receive_activity_led_b) else $error("rx led not low");
  a_src_field: assert property ($stable(active_cfg)[*2] |->
    tx_hdr_base.src == active_cfg.addr) else $error("sender field not own address");
  a_reply_hold: assert property (tx_byte_valid && !tx_byte_ready
    |=> tx_byte_valid && $stable(tx_byte)) else $error("reply byte dropped");
  a_busy_refuse: assert property (tx_byte_valid |-> !rx_byte_ready)
    else $error("command byte taken while replying");
  a_baud_sane: assert property (apply_req
    |=> active_cfg.baud inside {[BAUD_MIN:BAUD_MAX]})
    else $error("baud out of range after restart");

  c_report: cover property (fragment_received_indication);
  c_bcast: cover property (pkt_valid && pkt_hdr.dst == ADDR_BCAST ##1 pkt_accept);
  c_fallback: cover property (apply_req ##1 active_cfg.baud == DEF_BAUD);
endmodule : rms_settings_props

bind rms_settings rms_settings_props chk_u (.*);

// [bench/rms_host_model.sv]
module rms_host_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // Command bytes toward the device
  output logic            rx_byte_valid,
  output logic [7:0]      rx_byte,
  input  wire logic       rx_byte_ready,
  // Reply bytes from the device
  output logic            tx_byte_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q_q[$];
  logic       taken;
  logic [1:0] cnt;

  initial begin
    rx_byte_valid = 1'b0;
    rx_byte       = 8'h00;
    tx_byte_ready = 1'b0;
    cnt           = 2'h0;
  end

  // A byte changes just after the edge and holds until the device takes it
  always @(posedge clk_sys) begin
    taken = rx_byte_valid && rx_byte_ready;
    #1;
    if (taken)
      void'(q_q.pop_front());
    rx_byte_valid = rst_b && q_q.size() > 0;
    rx_byte       = rx_byte_valid ? q_q[0] : ~rx_byte; // Idle line shows junk, not old data
    cnt           = cnt + 2'h1;
    tx_byte_ready = cnt != 2'h0; // Stall one cycle in four to test holding
  end
endmodule : rms_host_model

// [bench/rms_settings_test.sv]
module rms_settings_test;
  import rms_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] rms_bq_t[$];
  logic clk_sys = 0, rst_b = 0, apply_req = 0, pkt_valid = 0, pkt_is_fragment = 0;
  logic radio_tx_busy = 0, radio_rx_busy = 0, rx_byte_valid, rx_byte_ready;
  logic tx_byte_valid, tx_byte_ready, pkt_accept, fragment_received_indication;
  logic fragment_drop, transmit_activity_led_b, receive_activity_led_b, frag_mode;
  logic [7:0] rx_byte, tx_byte, a;
  rms_hdr_t pkt_hdr = '0, tx_hdr_base;
  rms_cfg_t active_cfg;
  rms_bq_t exp_q;
  integer error_cnt = 0, n_tests = 0, seed = 32'h217C;
  logic [7:0] def_v[6] = '{DEF_CHANNEL, DEF_RATE, DEF_SUBNET, DEF_ADDR, DEF_POWER, DEF_FLAGS};
  logic [7:0] bad_v[8] = '{8'h00, 8'h30, 8'h33, 8'h63, 8'h66, 8'h92, 8'h99, 8'hCC};

  rms_settings dut_u (.*);
  rms_host_model host_u (.*);

  always #5 clk_sys = ~clk_sys;

  task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Frame with length and XOR checksum over every byte before it
  function automatic rms_bq_t build(input logic [7:0] cmd, input rms_bq_t body);
    rms_bq_t f;
    logic [7:0] cs;
    f = {FRAME_START, cmd, 8'(body.size())};
    f = {f, body};
    cs = 8'h00;
    foreach (f[i]) cs ^= f[i];
    f.push_back(cs);
    return f;
  endfunction : build

  // Next frame only once the previous reply is out
  task automatic xfer(input logic [7:0] cmd, input rms_bq_t body, input rms_bq_t rsp);
    int i;
    host_u.q_q = {host_u.q_q, build(cmd, body)};
    exp_q = {exp_q, rsp};
    for (i = 0; i < 300 && exp_q.size() > 0; i++) @(posedge clk_sys);
    #1;
    check("reply pending", exp_q.size(), 0);
  endtask : xfer

  task automatic set(input logic [7:0] off, input rms_bq_t d, input logic ok);
    xfer(CMD_SET, {off, d}, build(RSP_SET, {ok ? STATUS_OK : STATUS_FAIL}));
  endtask : set

  task automatic get(input logic [7:0] off, input rms_bq_t d);
    xfer(CMD_GET, {off, 8'(d.size())}, build(RSP_GET, {off, d}));
  endtask : get

  task automatic restart;
    apply_req = 1'b1;
    @(posedge clk_sys);
    #1 apply_req = 1'b0;
  endtask : restart

  // Peer sender is random but never our own address; an edge passes before the next header
  task automatic pkt(input logic [7:0] ch, sn, dst, input logic frag, acc, ind, drp);
    logic [7:0] src;
    src = 8'($random(seed));
    if (src == a) src = ~a;
    pkt_hdr = '{ch, sn, src, dst};
    pkt_is_fragment = frag;
    pkt_valid = 1'b1;
    @(posedge clk_sys);
    #1 pkt_valid = 1'b0;
    check("pkt_accept", pkt_accept, acc);
    check("frag_ind", fragment_received_indication, ind);
    check("frag_drop", fragment_drop, drp);
    @(posedge clk_sys);
    #1;
  endtask : pkt

  task automatic tally_and_finish;
    $display("Checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // Reply watcher: every byte handed over matches the oldest note
  always @(posedge clk_sys)
    if (tx_byte_valid && tx_byte_ready)
      check("tx_byte", tx_byte, exp_q.size() ? exp_q.pop_front() : 9'h1FF);

  // About twenty frames of under fifty cycles each, with a wide margin
  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    check("active_cfg", active_cfg, CFG_DEFAULT);
    foreach (def_v[i]) get(8'(i), {def_v[i]});
    get(OFF_BAUD, {8'h80, 8'h25, 8'h00, 8'h00});
    // Bad checksum is dropped without a reply
    host_u.q_q = {host_u.q_q, FRAME_START, CMD_GET, 8'h02, OFF_SUBNET, 8'h01, 8'h00};
    set(OFF_SUBNET, {8'h01}, 1'b1);
    check("subnet", active_cfg.subnet, DEF_SUBNET);
    restart();
    check("subnet", active_cfg.subnet, 8'h01);
    foreach (bad_v[i]) set(OFF_SUBNET, {bad_v[i]}, 1'b0);
    get(OFF_SUBNET, {8'h01});
    set(OFF_ADDR, {ADDR_BCAST}, 1'b0);
    a = 8'($unsigned($random(seed)) % 255);
    set(OFF_ADDR, {a}, 1'b1);
    set(OFF_BAUD, {8'h00, 8'hC2, 8'h01, 8'h00}, 1'b1);
    restart();
    check("tx src", tx_hdr_base.src, a);
    check("baud", active_cfg.baud, BAUD_MAX);
    pkt(DEF_CHANNEL, 8'h01, a, 1'b0, 1'b1, 1'b0, 1'b0);
    pkt(DEF_CHANNEL, 8'h01, ADDR_BCAST, 1'b0, 1'b1, 1'b0, 1'b0);
    pkt(DEF_CHANNEL, 8'h01, a == 8'h00 ? 8'h01 : a - 8'h01, 1'b0, 1'b0, 1'b0, 1'b0);
    pkt(DEF_CHANNEL, DEF_SUBNET, a, 1'b0, 1'b0, 1'b0, 1'b0);
    pkt(8'h07, 8'h01, ADDR_BCAST, 1'b0, 1'b0, 1'b0, 1'b0);
    pkt(DEF_CHANNEL, 8'h01, a, 1'b1, 1'b0, 1'b0, 1'b1);
    set(OFF_FLAGS, {8'h0B}, 1'b1);
    // Top byte set so that the fourth lane is exercised; value is out of range
    set(OFF_BAUD, {8'h64, 8'h00, 8'h00, 8'h01}, 1'b1);
    get(OFF_BAUD, {8'h64, 8'h00, 8'h00, 8'h01});
    restart();
    check("baud", active_cfg.baud, DEF_BAUD);
    check("frag_mode", frag_mode, 1'b1);
    pkt(DEF_CHANNEL, 8'h01, ADDR_BCAST, 1'b1, 1'b1, 1'b1, 1'b0);
    radio_tx_busy = 1'b1;
    radio_rx_busy = 1'b1;
    @(posedge clk_sys);
    #1;
    check("leds", {transmit_activity_led_b, receive_activity_led_b}, 2'b00);
    radio_tx_busy = 1'b0;
    radio_rx_busy = 1'b0;
    repeat (2) @(posedge clk_sys);
    tally_and_finish();
  end
endmodule : rms_settings_test
